// ==== hw/lin_mon_relay_pkg.sv ====
// Purpose: Shared constants for the LIN monitor and relay command block.
// Assumes: Commands arrive as a byte stream, first byte is the opcode.
// Notes: Response lengths and parameter byte positions are defined here once.
package lin_mon_relay_pkg;

  // ----------------------------------------------------------------
  // Opcodes
  // ----------------------------------------------------------------
  localparam logic [7:0] OP_MON_ACT = 8'h54;
  localparam logic [7:0] OP_SET = 8'h81;
  localparam logic [7:0] OP_RST = 8'h82;
  localparam logic [7:0] OP_DIRECT = 8'h83;
  localparam logic [7:0] OP_STATE = 8'h84;
  localparam logic [7:0] OP_GET_ITEMS = 8'hf2;

  // ----------------------------------------------------------------
  // Parameter byte positions and values
  // ----------------------------------------------------------------
  localparam int IDX_MODE = 0;
  localparam int IDX_SEL = 1;
  localparam int IDX_DRAIN = 2;
  localparam int IDX_FORMAT = 3;
  localparam int IDX_COUNT = 0;
  localparam int IDX_ALL = 1;
  localparam int IDX_MASK_LO = 0;
  localparam int IDX_MASK_HI = 1;
  localparam logic [8:0] LIST_START = 9'h004;
  localparam int PARAM_BYTES = 4;
  localparam logic [7:0] MODE_OFF = 8'h00;
  localparam logic [7:0] MODE_BUFFERED = 8'h01;
  localparam logic [7:0] SEL_MIN = 8'h01;
  localparam logic [7:0] SEL_MAX = 8'h07;
  localparam logic [7:0] DRAIN_AUTO = 8'h01;
  localparam logic [7:0] FORMAT_SMALL = 8'h01;
  localparam logic [7:0] APPLY_ALL = 8'h01;

  // ----------------------------------------------------------------
  // Capture classes; selection bit n enables event kind n
  // ----------------------------------------------------------------
  localparam logic [1:0] KIND_RX = 2'h0;
  localparam logic [1:0] KIND_TX = 2'h1;
  localparam logic [1:0] KIND_WAKE = 2'h2;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [15:0] RELAY_RESET = 16'h0000;
  localparam logic [2:0] SEL_RESET = 3'h0;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 25;
  localparam int TS_UNIT_NS = 1000;
  localparam int TS_TICK_CYCLES = TS_UNIT_NS / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // Responses
  // ----------------------------------------------------------------
  localparam logic [7:0] ENTRY_PRESENT = 8'h01;
  localparam logic [7:0] ENTRY_NONE = 8'h00;
  localparam logic [7:0] RSV_BYTE = 8'h00;
  localparam logic [2:0] ENTRY_RSP_LEN = 3'h6;
  localparam logic [2:0] EMPTY_RSP_LEN = 3'h2;
  localparam logic [2:0] STATE_RSP_LEN = 3'h5;
  localparam int ENTRY_W = 26;

endpackage

// ==== hw/entry_ram.sv ====
// Purpose: Storage for monitor entries, one write port, one read port.
// Assumes: Read address is stable; data appear one edge after the address.
// Notes: Read data always come from a register.
`timescale 1ns/10ps
module entry_ram #(
  parameter int W = 26,
  parameter int DEPTH = 64
) (
  // Clock
  input wire logic clk_sys,
  // Write side
  input wire logic wr_en,
  input wire logic [$clog2(DEPTH)-1:0] wr_addr,
  input wire logic [W-1:0] wr_data,
  // Read side
  input wire logic [$clog2(DEPTH)-1:0] rd_addr,
  output logic [W-1:0] rd_data
);

  logic [W-1:0] mem [DEPTH];

  always_ff @(posedge clk_sys) begin
    if (wr_en) begin
      mem[wr_addr] <= wr_data;
    end
    rd_data <= mem[rd_addr];
  end

endmodule

// ==== hw/lin_mon_relay_cmd.sv ====
// Purpose: Command interpreter for LIN monitor activation and relay control.
// Assumes: One command byte per cycle when cmd_valid; no back-pressure.
// Notes: Responses leave as a byte stream under rsp_valid/rsp_ready.
//
// Notes on behaviour
// - Activation byte 0: value 0 turns monitor off, 1 turns buffered capture on.
// - Selection byte: 1 rx, 2 tx, 3 both, 4 wake, 5..7 wake plus frames.
// - Drain byte: 0 holds entries for host, 1 pushes them out automatically.
// - Only entry format 1, compact entries, is accepted.
// - No entries are captured while the slave task is switched off.
// - Auto-drain pushes entries unasked; host must read them periodically.
// - Pushed entries use the same layout as the item retrieval reply.
// - Activation with action 1 clears the entry time-stamp timer to zero.
// - Set command energises all relays, or only listed ones.
// - Byte 0 holds count N, bytes 2 and 3 reserved, list from byte 4.
// - Reset command de-energises all relays, or only listed ones.
// - Direct write: 16-bit mask in bytes 0 and 1, bit 0 is relay 1.
// - State query has no parameters; reply carries mask then two reserved bytes.
// - A one bit in the reply means the relay is set.
// - Accepted frames go into a ring buffer in bus order.
`timescale 1ns/10ps
module lin_mon_relay_cmd #(
  parameter int N_RELAY = 16,
  parameter int DEPTH = 64
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Command byte stream
  input wire logic cmd_valid,
  input wire logic cmd_first,
  input wire logic cmd_last,
  input wire logic [7:0] cmd_byte,
  // Bus events from the LIN engine
  input wire logic slave_task_on,
  input wire logic ev_valid,
  input wire logic ev_pass,
  input wire logic [1:0] ev_kind,
  input wire logic [7:0] ev_id,
  // Response byte stream
  input wire logic rsp_ready,
  output logic rsp_valid,
  output logic rsp_last,
  output logic [7:0] rsp_byte,
  // Status and relay drive
  output logic [N_RELAY-1:0] relay_state,
  output logic mon_active,
  output logic auto_drain,
  output logic buf_overflow
);
  import lin_mon_relay_pkg::*;

  localparam int AW = $clog2(DEPTH);

  if (N_RELAY < 1 || N_RELAY > 16) begin : g_bad_relay
    $error("N_RELAY must be 1..16");
  end
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("DEPTH must be a power of two, at least 2");
  end

  typedef enum logic {ST_IDLE, ST_SEND} rsp_state_e;

  // ----------------------------------------------------------------
  // Command capture
  // ----------------------------------------------------------------
  logic [7:0] op_r;
  logic [8:0] idx_r;
  logic [7:0] p_r [PARAM_BYTES];
  logic [7:0] p_w [PARAM_BYTES];
  logic [15:0] list_r;
  logic [15:0] cur_bit;
  logic [7:0] op_w;
  logic param_byte, fin, in_list, list_op;

  assign op_w = cmd_first ? cmd_byte : op_r;
  assign param_byte = cmd_valid & ~cmd_first;
  assign fin = cmd_valid & cmd_last;
  assign list_op = (op_r == OP_SET) | (op_r == OP_RST);
  // Count is read from the stored byte 0; the list starts at byte 4.
  assign in_list = param_byte & list_op & (idx_r >= LIST_START) &
                   ((idx_r - LIST_START) < {1'b0, p_r[IDX_COUNT]});

  genvar gi;
  generate
    for (gi = 0; gi < PARAM_BYTES; gi++) begin : g_par
      // The final byte of a command is folded in before it is stored.
      // An opcode clears the bytes, so a short command never reuses old ones.
      assign p_w[gi] = (cmd_valid && cmd_first) ? 8'h00 :
                       (param_byte && idx_r == 9'(gi)) ? cmd_byte : p_r[gi];
      always_ff @(posedge clk_sys) begin
        if (rst) begin
          p_r[gi] <= 8'h00;
        end else begin
          p_r[gi] <= p_w[gi];
        end
      end
    end
    for (gi = 0; gi < 16; gi++) begin : g_list
      if (gi < N_RELAY) begin : g_on
        assign cur_bit[gi] = in_list & (cmd_byte == 8'(gi + 1));
      end else begin : g_off
        assign cur_bit[gi] = 1'b0;
      end
    end
  endgenerate

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      op_r <= 8'h00;
      idx_r <= 9'h000;
      list_r <= 16'h0000;
    end else if (cmd_valid) begin
      op_r <= op_w;
      idx_r <= cmd_first ? 9'h000 : (idx_r == 9'h1ff ? idx_r : idx_r + 9'h001);
      list_r <= cmd_first ? 16'h0000 : (list_r | cur_bit);
    end
  end

  // ----------------------------------------------------------------
  // Relays
  // ----------------------------------------------------------------
  logic [N_RELAY-1:0] relay_r, relay_nxt, list_w, mask_w;
  logic [15:0] relay_map;
  logic apply_all;

  assign list_w = N_RELAY'(cmd_first ? 16'h0000 : (list_r | cur_bit));
  assign mask_w = N_RELAY'({p_w[IDX_MASK_HI], p_w[IDX_MASK_LO]});
  assign apply_all = (p_w[IDX_ALL] == APPLY_ALL);

  always_comb begin
    relay_nxt = relay_r;
    if (fin) begin
      case (op_w)
        OP_SET: relay_nxt = apply_all ? '1 : (relay_r | list_w);
        OP_RST: relay_nxt = apply_all ? '0 : (relay_r & ~list_w);
        OP_DIRECT: relay_nxt = mask_w;
        default: relay_nxt = relay_r;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      relay_r <= N_RELAY'(RELAY_RESET);
    end else begin
      relay_r <= relay_nxt;
    end
  end

  generate
    for (gi = 0; gi < 16; gi++) begin : g_map
      if (gi < N_RELAY) begin : g_on
        assign relay_map[gi] = relay_r[gi];
      end else begin : g_off
        assign relay_map[gi] = 1'b0;
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // Monitor control
  // ----------------------------------------------------------------
  logic mon_r, auto_r, act_on, act_off, drain_w;
  logic [2:0] sel_r;

  assign drain_w = (p_w[IDX_DRAIN] == DRAIN_AUTO);

  assign act_off = fin & (op_w == OP_MON_ACT) & (p_w[IDX_MODE] == MODE_OFF);
  // Activation with an unsupported format or an empty selection is ignored.
  assign act_on = fin & (op_w == OP_MON_ACT) & (p_w[IDX_MODE] == MODE_BUFFERED) &
                  (p_w[IDX_FORMAT] == FORMAT_SMALL) &
                  (p_w[IDX_SEL] >= SEL_MIN) & (p_w[IDX_SEL] <= SEL_MAX);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      mon_r <= 1'b0;
      auto_r <= 1'b0;
      sel_r <= SEL_RESET;
    end else if (act_on) begin
      mon_r <= 1'b1;
      sel_r <= p_w[IDX_SEL][2:0];
      auto_r <= drain_w;
    end else if (act_off) begin
      mon_r <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Time stamp
  // ----------------------------------------------------------------
  logic [$clog2(TS_TICK_CYCLES)-1:0] pre_r;
  logic [15:0] ts_r;
  logic tick;

  assign tick = (pre_r == ($clog2(TS_TICK_CYCLES))'(TS_TICK_CYCLES - 1));

  always_ff @(posedge clk_sys) begin
    if (rst || act_on) begin
      pre_r <= '0;
      ts_r <= 16'h0000;
    end else begin
      pre_r <= tick ? '0 : pre_r + 1'b1;
      ts_r <= tick ? ts_r + 16'h0001 : ts_r;
    end
  end

  // ----------------------------------------------------------------
  // Ring buffer
  // ----------------------------------------------------------------
  logic [AW-1:0] wr_ptr_r, rd_ptr_r;
  logic [AW:0] cnt_r;
  logic [ENTRY_W-1:0] rd_entry;
  logic accept, push, pop, full, avail_r, ovf_r;
  logic [3:0] sel_ext;

  // Kind 3 indexes the padding bit, so it is never stored.
  assign sel_ext = {1'b0, sel_r};

  assign full = (cnt_r == (AW + 1)'(DEPTH));
  assign accept = mon_r & slave_task_on & ev_valid & ev_pass &
                  (ev_kind <= KIND_WAKE) & sel_ext[ev_kind];
  assign push = accept & ~full;

  always_ff @(posedge clk_sys) begin
    if (rst || act_on) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r <= '0;
      avail_r <= 1'b0;
      // An event lost in the very cycle of an activation still raises the flag.
      ovf_r <= !rst && accept && full;
    end else begin
      wr_ptr_r <= wr_ptr_r + AW'(push);
      rd_ptr_r <= rd_ptr_r + AW'(pop);
      cnt_r <= cnt_r + (AW + 1)'(push) - (AW + 1)'(pop);
      // Read data lag the pointer by one edge, so availability lags too.
      avail_r <= (cnt_r != '0) & ~pop;
      ovf_r <= ovf_r | (accept & full);
    end
  end

  entry_ram #(.W(ENTRY_W), .DEPTH(DEPTH)) u_ram (
    .clk_sys(clk_sys),
    .wr_en(push),
    .wr_addr(wr_ptr_r),
    .wr_data({ev_kind, ev_id, ts_r}),
    .rd_addr(rd_ptr_r),
    .rd_data(rd_entry)
  );

  // ----------------------------------------------------------------
  // Response sender
  // ----------------------------------------------------------------
  rsp_state_e st_r;
  logic state_pend_r, items_pend_r;
  logic go_state, go_items, go_auto, go, idle;
  logic [47:0] ld_w, sh_r;
  logic [2:0] ld_len, len_r;
  logic [7:0] byte_r;
  logic valid_r, last_r, take;
  logic [47:0] entry_rsp;

  assign idle = (st_r == ST_IDLE);
  assign go_state = idle & state_pend_r;
  assign go_items = idle & ~state_pend_r & items_pend_r;
  assign go_auto = idle & ~state_pend_r & ~items_pend_r & auto_r & avail_r;
  assign go = go_state | go_items | go_auto;
  assign pop = (go_items & avail_r) | go_auto;
  assign take = valid_r & rsp_ready;
  // One entry per reply; kind, id, then time stamp high byte before low byte on the wire.
  assign entry_rsp = {rd_entry[7:0], rd_entry[15:8], rd_entry[23:16],
                      6'h00, rd_entry[25:24], ENTRY_PRESENT, OP_GET_ITEMS};

  always_comb begin
    ld_w = 48'h0;
    ld_len = EMPTY_RSP_LEN;
    if (go_state) begin
      ld_w = {8'h00, RSV_BYTE, RSV_BYTE, relay_map[15:8], relay_map[7:0], OP_STATE};
      ld_len = STATE_RSP_LEN;
    end else if (avail_r) begin
      ld_w = entry_rsp;
      ld_len = ENTRY_RSP_LEN;
    end else begin
      ld_w = {32'h0, ENTRY_NONE, OP_GET_ITEMS};
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      state_pend_r <= 1'b0;
      items_pend_r <= 1'b0;
    end else begin
      // A new request in the cycle its reply starts stays pending.
      state_pend_r <= (fin & (op_w == OP_STATE)) | (state_pend_r & ~go_state);
      items_pend_r <= (fin & (op_w == OP_GET_ITEMS)) | (items_pend_r & ~go_items);
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      st_r <= ST_IDLE;
      sh_r <= 48'h0;
      len_r <= 3'h0;
      byte_r <= 8'h00;
      valid_r <= 1'b0;
      last_r <= 1'b0;
    end else begin
      case (st_r)
        ST_IDLE: begin
          if (go) begin
            st_r <= ST_SEND;
            byte_r <= ld_w[7:0];
            sh_r <= ld_w >> 8;
            len_r <= ld_len - 3'h1;
            valid_r <= 1'b1;
            last_r <= (ld_len == 3'h1);
          end
        end
        ST_SEND: begin
          if (take && last_r) begin
            st_r <= ST_IDLE;
            valid_r <= 1'b0;
            last_r <= 1'b0;
          end else if (take) begin
            byte_r <= sh_r[7:0];
            sh_r <= sh_r >> 8;
            len_r <= len_r - 3'h1;
            last_r <= (len_r == 3'h1);
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  assign rsp_valid = valid_r;
  assign rsp_last = last_r;
  assign rsp_byte = byte_r;
  assign relay_state = relay_r;
  assign mon_active = mon_r;
  assign auto_drain = auto_r;
  assign buf_overflow = ovf_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  property p_off;
    @(posedge clk_sys) disable iff (rst) act_off |=> !mon_active;
  endproperty
  a_off: assert property (p_off) else $error("monitor still on after off");

  property p_on;
    @(posedge clk_sys) disable iff (rst)
      act_on |=> mon_active && auto_drain == $past(drain_w);
  endproperty
  a_on: assert property (p_on) else $error("activation not taken");

  property p_sel;
    @(posedge clk_sys) disable iff (rst) push |-> sel_ext[ev_kind] && mon_r;
  endproperty
  a_sel: assert property (p_sel) else $error("unselected event stored");

  property p_slave;
    @(posedge clk_sys) disable iff (rst) !slave_task_on |-> !push;
  endproperty
  a_slave: assert property (p_slave) else $error("capture with slave off");

  property p_ts;
    @(posedge clk_sys) disable iff (rst) act_on |=> ts_r == 16'h0000 ##1 ts_r == 16'h0000;
  endproperty
  a_ts: assert property (p_ts) else $error("time stamp not cleared");

  property p_all;
    @(posedge clk_sys) disable iff (rst)
      fin && apply_all && (op_w == OP_SET || op_w == OP_RST) |=>
        relay_state == ($past(op_w) == OP_SET ? {N_RELAY{1'b1}} : {N_RELAY{1'b0}});
  endproperty
  a_all: assert property (p_all) else $error("apply-to-every wrong");

  property p_direct;
    @(posedge clk_sys) disable iff (rst)
      fin && op_w == OP_DIRECT |=> relay_state == $past(mask_w);
  endproperty
  a_direct: assert property (p_direct) else $error("direct write wrong");

  sequence s_state_req;
    fin && op_w == OP_STATE;
  endsequence
  sequence s_state_rsp;
    rsp_valid && rsp_byte == OP_STATE;
  endsequence
  property p_state;
    @(posedge clk_sys) disable iff (rst) s_state_req |-> ##[1:20] s_state_rsp;
  endproperty
  a_state: assert property (p_state) else $error("state reply missing");

  property p_ring;
    @(posedge clk_sys) disable iff (rst || act_on) push |=> wr_ptr_r == $past(wr_ptr_r) + 1'b1;
  endproperty
  a_ring: assert property (p_ring) else $error("ring pointer stuck");

  property p_auto;
    @(posedge clk_sys) disable iff (rst) go_auto |=> rsp_valid && rsp_byte == OP_GET_ITEMS;
  endproperty
  a_auto: assert property (p_auto) else $error("auto drain reply wrong");

endmodule

// ==== tb/host_reader.sv ====
// Purpose: Host-side reader of the response byte stream.
// Assumes: A byte leaves on a rising edge with rsp_valid and rsp_ready high.
// Notes: In slow mode the host reads only one cycle in three.
`timescale 1ns/10ps
module host_reader (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  // Pace control
  input wire logic slow,
  // Response stream
  output logic rsp_ready
);
  logic [1:0] pace_r;
  // ----------------------------------------------------------------
  // Periodic read-out
  // ----------------------------------------------------------------
  // The host polls on its own schedule, so stalls also land in mid-reply.
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      pace_r <= 2'h0;
      rsp_ready <= 1'b0;
    end else begin
      pace_r <= (pace_r == 2'h2) ? 2'h0 : pace_r + 2'h1;
      rsp_ready <= !slow || (pace_r == 2'h2);
    end
  end
endmodule

// ==== tb/lin_mon_relay_cmd_tb_top.sv ====
// Purpose: Self-checking bench for the monitor and relay command block.
// Assumes: Response bytes are compared in order against a queue of notes.
// Notes: Time stamps are expected at zero, events follow activation closely.
`timescale 1ns/10ps
module lin_mon_relay_cmd_tb_top;
  import lin_mon_relay_pkg::*;
  logic clk_sys = 1'b0, rst = 1'b1, slow = 1'b0;
  logic cmd_valid = 1'b0, cmd_first = 1'b0, cmd_last = 1'b0;
  logic [7:0] cmd_byte = 8'h00, ev_id = 8'h00;
  logic slave_task_on = 1'b1, ev_valid = 1'b0, ev_pass = 1'b0;
  logic [1:0] ev_kind = 2'h0;
  logic rsp_ready, rsp_valid, rsp_last, mon_active, auto_drain, buf_overflow;
  logic [7:0] rsp_byte;
  logic [15:0] relay_state, m;
  logic [7:0] cmd_q[$];
  logic [9:0] exp_q[$];
  logic [7:0] ids[0:2];
  logic [9:0] e;
  int n_errors = 0, n_compared = 0, seed = 45, cnt;

  lin_mon_relay_cmd dut (.clk_sys(clk_sys), .rst(rst), .cmd_valid(cmd_valid),
    .cmd_first(cmd_first), .cmd_last(cmd_last), .cmd_byte(cmd_byte),
    .slave_task_on(slave_task_on), .ev_valid(ev_valid), .ev_pass(ev_pass),
    .ev_kind(ev_kind), .ev_id(ev_id), .rsp_ready(rsp_ready), .rsp_valid(rsp_valid),
    .rsp_last(rsp_last), .rsp_byte(rsp_byte), .relay_state(relay_state),
    .mon_active(mon_active), .auto_drain(auto_drain), .buf_overflow(buf_overflow));
  host_reader host (.clk_sys(clk_sys), .rst(rst), .slow(slow), .rsp_ready(rsp_ready));

  initial begin
    forever #12.5 clk_sys = ~clk_sys;
  end

  task fail(input string msg);
    n_errors++;
    $display("MISMATCH at %0t: %s", $time, msg);
  endtask

  task chk(input logic [15:0] got, input logic [15:0] exp, input string msg);
    n_compared++;
    if (got !== exp) fail(msg);
  endtask

  task test_done();
    $display("Compared %0d, errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask

  task send();
    for (int i = 0; i < cmd_q.size(); i++) begin
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_first <= (i == 0);
      cmd_last <= (i == cmd_q.size() - 1);
      cmd_byte <= cmd_q[i];
    end
    @(posedge clk_sys);
    cmd_valid <= 1'b0;
    cmd_first <= 1'b0;
    cmd_last <= 1'b0;
    cmd_q.delete();
    @(posedge clk_sys);
  endtask

  task expect_b(input logic [7:0] b, input logic last);
    exp_q.push_back({last, 1'b0, b});
  endtask

  task wait_drain();
    cnt = 0;
    while (exp_q.size() != 0 && cnt < 3000) begin
      @(posedge clk_sys);
      cnt++;
    end
    if (exp_q.size() != 0) fail("reply missing");
    exp_q.delete();
    repeat (3) @(posedge clk_sys);
  endtask

  task query(input logic [15:0] mask);
    expect_b(OP_STATE, 1'b0);
    expect_b(mask[7:0], 1'b0);
    expect_b(mask[15:8], 1'b0);
    expect_b(8'h00, 1'b0);
    expect_b(8'h00, 1'b1);
    cmd_q = '{OP_STATE};
    send();
    wait_drain();
  endtask

  task entry(input logic [1:0] kind, input logic [7:0] id);
    expect_b(OP_GET_ITEMS, 1'b0);
    expect_b(ENTRY_PRESENT, 1'b0);
    expect_b({6'h00, kind}, 1'b0);
    expect_b(id, 1'b0);
    expect_b(8'h00, 1'b0);
    expect_b(8'h00, 1'b1);
  endtask

  task fetch();
    cmd_q = '{OP_GET_ITEMS};
    send();
    wait_drain();
  endtask

  task bus_ev(input logic [1:0] kind, input logic [7:0] id, input logic pass);
    @(posedge clk_sys);
    ev_valid <= 1'b1;
    ev_pass <= pass;
    ev_kind <= kind;
    ev_id <= id;
    @(posedge clk_sys);
    ev_valid <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // Response watcher
  // ----------------------------------------------------------------
  always @(posedge clk_sys) begin
    if (!rst && rsp_valid === 1'b1 && rsp_ready === 1'b1) begin
      if (exp_q.size() == 0) begin
        fail("unexpected response byte");
      end else begin
        e = exp_q.pop_front();
        n_compared++;
        if (rsp_byte !== e[7:0] || rsp_last !== e[9]) fail("response byte differs");
      end
    end
  end

  initial begin
    repeat (50000) @(posedge clk_sys);
    fail("watchdog expired");
    test_done();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (4) @(posedge clk_sys);
    rst <= 1'b0;
    query(RELAY_RESET);
    m = 16'($random(seed));
    cmd_q = '{OP_DIRECT, m[7:0], m[15:8], 8'h00, 8'h00};
    send();
    chk(relay_state, m, "direct mask");
    query(m);
    cmd_q = '{OP_SET, 8'h00, APPLY_ALL, 8'h00, 8'h00};
    send();
    chk(relay_state, 16'hffff, "set all");
    // Relay 17 and the byte past the count must have no effect.
    cmd_q = '{OP_RST, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01, 8'h10, 8'h11, 8'h02};
    send();
    chk(relay_state, 16'h7ffe, "reset list");
    cmd_q = '{OP_RST, 8'h00, APPLY_ALL, 8'h00, 8'h00};
    send();
    chk(relay_state, 16'h0000, "reset all");
    cmd_q = '{OP_SET, 8'h03, 8'h00, 8'haa, 8'hbb, 8'h00, 8'h05, 8'h10};
    send();
    chk(relay_state, 16'h8010, "set list");
    query(16'h8010);
    // Capture is blocked while the slave task is off.
    slave_task_on <= 1'b0;
    cmd_q = '{OP_MON_ACT, MODE_BUFFERED, 8'h07, 8'h00, FORMAT_SMALL};
    send();
    chk({15'h0, mon_active}, 16'h0001, "monitor on");
    chk({15'h0, auto_drain}, 16'h0000, "on request");
    bus_ev(KIND_RX, 8'h21, 1'b1);
    expect_b(OP_GET_ITEMS, 1'b0);
    expect_b(ENTRY_NONE, 1'b1);
    fetch();
    slave_task_on <= 1'b1;
    slow <= 1'b1;
    for (int s = 1; s <= 7; s++) begin
      cmd_q = '{OP_MON_ACT, MODE_BUFFERED, s[7:0], 8'h00, FORMAT_SMALL};
      send();
      for (int k = 0; k < 3; k++) begin
        ids[k] = 8'($random(seed));
        bus_ev(k[1:0], ids[k], 1'b1);
      end
      bus_ev(KIND_RX, 8'h3f, 1'b0);
      for (int k = 0; k < 3; k++) begin
        if (s[k]) begin
          entry(k[1:0], ids[k]);
          fetch();
        end
      end
      expect_b(OP_GET_ITEMS, 1'b0);
      expect_b(ENTRY_NONE, 1'b1);
      fetch();
    end
    // A full ring refuses the next event, flags it and keeps the oldest entry first.
    cmd_q = '{OP_MON_ACT, MODE_BUFFERED, 8'h01, 8'h00, FORMAT_SMALL};
    send();
    for (int k = 0; k <= 64; k++) begin
      bus_ev(KIND_RX, 8'(k + 1), 1'b1);
    end
    @(posedge clk_sys);
    chk({15'h0, buf_overflow}, 16'h0001, "overflow flag");
    entry(KIND_RX, 8'h01);
    fetch();
    cmd_q = '{OP_MON_ACT, MODE_OFF, 8'h00, 8'h00, 8'h00};
    send();
    chk({15'h0, mon_active}, 16'h0000, "monitor off");
    cmd_q = '{OP_MON_ACT, MODE_BUFFERED, 8'h01, 8'h00, 8'h02};
    send();
    chk({15'h0, mon_active}, 16'h0000, "bad format taken");
    cmd_q = '{OP_MON_ACT, MODE_BUFFERED, 8'h01, DRAIN_AUTO, FORMAT_SMALL};
    send();
    chk({15'h0, auto_drain}, 16'h0001, "auto drain");
    chk({15'h0, buf_overflow}, 16'h0000, "overflow not cleared");
    ids[0] = 8'($random(seed));
    entry(KIND_RX, ids[0]);
    bus_ev(KIND_RX, ids[0], 1'b1);
    wait_drain();
    // Item retrieval on an empty ring while pushes are on.
    expect_b(OP_GET_ITEMS, 1'b0);
    expect_b(ENTRY_NONE, 1'b1);
    fetch();
    test_done();
  end
endmodule
